// File: verif/host_cpu_ram_register_port_tb.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module host_cpu_ram_register_port_tb;
   import host_port_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic dmaAck_n = 1'b1;
   logic transp = 1'b1;
   logic wide = 1'b1;
   logic trig = 1'b0;
   logic late = 1'b0;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic reqMem = 1'b0;
   logic reqMsb = 1'b0;
   logic [15:0] reqAddr = 16'h0000;
   logic [15:0] reqData = 16'h0000;
   logic reqReady;
   logic rspValid;
   logic [15:0] rspData;
   logic accReq;
   logic [15:0] rd;
   int bad_count = 0;
   int cmp_count = 0;
   host_port_if bus_if();
   host_port_if bad_if();
   always #2 core_clk = ~core_clk;
   host_port_host host_port_host_i (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if.host),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqMem(reqMem), .reqMsb(reqMsb),
      .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData));
   host_port_device host_port_device_i (.core_clk(core_clk), .rst_n(rst_n),
      .bus(bus_if.device), .dma_transfer_ack_n(dmaAck_n), .transparent_strap(transp),
      .bus_width_strap(wide), .trigger_sel_strap(trig), .late_select_strap(late),
      .hostAccessReq(accReq));
   host_port_device host_port_device_i2 (.core_clk(core_clk), .rst_n(rst_n),
      .bus(bad_if.device), .dma_transfer_ack_n(1'b1), .transparent_strap(transp),
      .bus_width_strap(wide), .trigger_sel_strap(trig), .late_select_strap(1'b1),
      .hostAccessReq());
   host_port_props host_port_props_i (.core_clk(core_clk), .rst_n(rst_n),
      .strobe_n(bus_if.strobe_n), .select_n(bus_if.select_n), .memReg(bus_if.memReg),
      .rdWr(bus_if.rdWr), .devDataOe(bus_if.devDataOe), .io_enable_n(bus_if.io_enable_n),
      .host_ready_n(bus_if.host_ready_n), .ext_mem_enable_n(bus_if.ext_mem_enable_n),
      .ext_mem_write_n(bus_if.ext_mem_write_n), .dma_transfer_ack_n(dmaAck_n),
      .bus_width_strap(wide), .late_select_strap(late));
   // ==========================================================
   // Shared tasks.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Runs one host request and waits for the host end to go idle again.
   task automatic op(input logic w, input logic m, input logic b, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q);
      int n;
      q = 16'h0000;
      {reqWrite, reqMem, reqMsb, reqAddr, reqData} = {w, m, b, a, d};
      reqValid = 1'b1;
      @(negedge core_clk);
      reqValid = 1'b0;
      for (n = 0; reqReady !== 1'b0 && n < 9; n++) @(negedge core_clk);
      if (n == 9) begin
         chk("request taken", 16'h0001, 16'h0000);
         wrap_up();
      end
      for (n = 0; reqReady !== 1'b1 && n < 900; n++) begin
         @(negedge core_clk);
         if (rspValid === 1'b1) q = rspData;
      end
      if (n == 900) begin
         chk("request done", 16'h0001, 16'h0000);
         wrap_up();
      end
   endtask
   task automatic rdk(input string what, input logic m, input logic [15:0] a,
      input logic [15:0] exp);
      op(1'b0, m, 1'b0, a, 16'h0000, rd);
      chk(what, exp, rd);
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_word();
      op(1'b1, 1'b1, 1'b0, 16'h0005, 16'h1234, rd);
      op(1'b1, 1'b1, 1'b0, 16'h1005, 16'hA5C3, rd);
      rdk("ram alias", 1'b1, 16'h0005, 16'hA5C3);
      rdk("ram high bits", 1'b1, 16'hF005, 16'hA5C3);
      op(1'b1, 1'b0, 1'b0, 16'h0003, 16'h5A5A, rd);
      rdk("reg alias", 1'b0, 16'h0023, 16'h5A5A);
      $display("word test done");
   endtask
   task automatic t_bytes();
      logic [7:0] nt;
      for (int t = 0; t < 2; t++) begin
         nt = 8'h3C ^ 8'(t);
         {wide, transp, trig} = {2'b00, t[0]};
         op(1'b1, 1'b1, ~trig, 16'h0040, {nt, nt}, rd);
         op(1'b1, 1'b1, trig, 16'h0040, 16'hC6C6, rd);
         op(1'b0, 1'b1, trig, 16'h0040, 16'h0000, rd);
         chk("trigger byte", 16'h00C6, {8'h00, rd[7:0]});
         op(1'b0, 1'b1, ~trig, 16'h0040, 16'h0000, rd);
         chk("kept byte", {8'h00, nt}, {8'h00, rd[7:0]});
         {wide, transp} = 2'b11;
         rdk("paired word", 1'b1, 16'h0040, trig ? {8'hC6, nt} : {nt, 8'hC6});
      end
      $display("byte test done");
   endtask
   task automatic t_dma();
      dmaAck_n = 1'b0;
      fork
         op(1'b1, 1'b1, 1'b0, 16'h0100, 16'h0F0F, rd);
         begin
            repeat (20) @(negedge core_clk);
            chk("grant held", 16'h0001, {15'h0000, bus_if.io_enable_n});
            chk("access request", 16'h0001, {15'h0000, accReq});
            dmaAck_n = 1'b1;
         end
      join
      rdk("after dma", 1'b1, 16'h0100, 16'h0F0F);
      dmaAck_n = 1'b0;
      rdk("forced grant", 1'b1, 16'h0100, 16'h0F0F);
      dmaAck_n = 1'b1;
      $display("dma test done");
   endtask
   task automatic t_late();
      late = 1'b1;
      op(1'b1, 1'b1, 1'b0, 16'h0200, 16'h7E81, rd);
      rdk("late word", 1'b1, 16'h0200, 16'h7E81);
      late = 1'b0;
      bad_if.strobe_n = 1'b0;
      repeat (2) @(negedge core_clk);
      bad_if.select_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("late refused", 16'h0001, {15'h0000, bad_if.io_enable_n});
      bad_if.strobe_n = 1'b1;
      repeat (2) @(negedge core_clk);
      bad_if.strobe_n = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("late grant", 16'h0000, {15'h0000, bad_if.io_enable_n});
      bad_if.strobe_n = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("abort", 16'h0006, {13'h0000, bad_if.io_enable_n, bad_if.host_ready_n,
         bad_if.devDataOe});
      bad_if.select_n = 1'b1;
      $display("late select test done");
   endtask
   initial begin
      bad_if.strobe_n = 1'b1;
      bad_if.select_n = 1'b1;
      bad_if.memReg = 1'b1;
      bad_if.rdWr = 1'b1;
      bad_if.msbLsb = 1'b0;
      bad_if.addr = 16'h0010;
      bad_if.hostData = 16'h0000;
      bad_if.hostDataOe = 1'b0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      t_word();
      t_bytes();
      t_dma();
      t_late();
      wrap_up();
   end
endmodule
`default_nettype wire

// File: verif/host_port_props.sv
// Checker for the signals between the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module host_port_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic strobe_n,
   input wire logic select_n,
   input wire logic memReg,
   input wire logic rdWr,
   input wire logic devDataOe,
   input wire logic io_enable_n,
   input wire logic host_ready_n,
   input wire logic ext_mem_enable_n,
   input wire logic ext_mem_write_n,
   input wire logic dma_transfer_ack_n,
   input wire logic bus_width_strap,
   input wire logic late_select_strap
);
   logic [11:0] waitCnt_ff;
   logic [11:0] nxt_waitCnt;
   // ==========================================================
   // Wait counter.
   // Counts the cycles a strobed request waits for its grant.
   always_comb begin
      nxt_waitCnt = (!strobe_n && io_enable_n) ? waitCnt_ff + 12'h001 : 12'h000;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         waitCnt_ff <= 12'h000;
      end else begin
         waitCnt_ff <= nxt_waitCnt;
      end
   end
   // ==========================================================
   // Assertions.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_grant_first_edge: assert property (
      !late_select_strap && io_enable_n && $past(strobe_n) && !strobe_n && !select_n
      && dma_transfer_ack_n |=> !io_enable_n) else $error("grant missed");
   a_late_grant: assert property (
      late_select_strap && io_enable_n && $fell(strobe_n) ##1
      (!select_n && !strobe_n && dma_transfer_ack_n) |=> !io_enable_n) else $error("late grant");
   a_late_refused: assert property (
      late_select_strap && io_enable_n && $fell(strobe_n) ##1 select_n
      |=> io_enable_n [*4]) else $error("late select granted");
   a_late_first_edge: assert property (
      late_select_strap && $fell(strobe_n) |-> io_enable_n ##1 io_enable_n)
      else $error("late select sampled early");
   a_dma_holdoff: assert property (
      io_enable_n && !dma_transfer_ack_n && waitCnt_ff < 12'h1F4 |=> io_enable_n)
      else $error("grant during dma");
   a_grant_bound: assert property (
      waitCnt_ff < 12'h230) else $error("grant wait too long");
   a_ready_delay: assert property (
      $fell(io_enable_n) ##49 !io_enable_n |-> host_ready_n ##1 !host_ready_n)
      else $error("ready timing");
   a_data_lead: assert property (
      $fell(host_ready_n) && devDataOe |-> $past(devDataOe, 5)) else $error("data late");
   a_end_release: assert property (
      !io_enable_n && strobe_n |=> io_enable_n && host_ready_n && ext_mem_enable_n
      && !devDataOe) else $error("cycle not ended");
   a_reg_no_mem: assert property (
      !io_enable_n && !memReg && !rdWr |-> ext_mem_enable_n && ext_mem_write_n)
      else $error("memory strobe on register write");
   a_mem_enable_lag: assert property (
      $fell(io_enable_n) && memReg && bus_width_strap |-> ext_mem_enable_n ##1
      !ext_mem_enable_n) else $error("memory enable timing");
   a_write_pulse: assert property (
      $fell(io_enable_n) && memReg && !rdWr && bus_width_strap |-> ##2 ext_mem_write_n
      ##1 !ext_mem_write_n ##1 ext_mem_write_n) else $error("write pulse timing");
endmodule
`default_nettype wire

// File: verilog/host_port_device.sv
// Device end of the host port: arbitration, latching, RAM and registers.
// ==========================================================
`timescale 1ns/10ps
`default_nettype none
module host_port_device
   import host_port_pkg::*;
#(
   parameter int RAM_WORDS = 4096,
   parameter int REG_WORDS = 32
) (
   input wire logic core_clk,
   input wire logic rst_n,
   host_port_if.device bus,
   input wire logic dma_transfer_ack_n,
   input wire logic transparent_strap,
   input wire logic bus_width_strap,
   input wire logic trigger_sel_strap,
   input wire logic late_select_strap,
   output logic hostAccessReq
);
   typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_WAIT, ST_ACT, ST_DONE, ST_SKIP} state_t;

   // ==========================================================
   // State.
   state_t state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic io_enable_n_ff, nxt_io_enable_n;
   logic ready_ff, nxt_ready;
   logic memEn_ff, nxt_memEn;
   logic ext_mem_write_n_ff, nxt_ext_mem_write_n;
   logic oe_ff, nxt_oe;
   logic [DATA_W-1:0] dOut_ff, nxt_dOut;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] wData_ff, nxt_wData;
   logic memReg_ff, nxt_memReg;
   logic rdWr_ff, nxt_rdWr;
   logic msb_ff, nxt_msb;
   logic [7:0] byteHold_ff, nxt_byteHold;
   logic [DATA_W-1:0] word_ff, nxt_word;
   logic req_ff, nxt_req;
   logic ramWe, regWe;
   logic [DATA_W-1:0] weData;
   logic [DATA_W-1:0] ram [0:RAM_WORDS-1];
   logic [DATA_W-1:0] regs [0:REG_WORDS-1];
   logic wide, trig, grant;

   assign wide = bus_width_strap;
   assign trig = wide || (msb_ff == trigger_sel_strap);
   assign grant = dma_transfer_ack_n || (cnt_ff >= CONTEND_CNT);

   // ==========================================================
   // Next-state logic.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_io_enable_n = io_enable_n_ff;
      nxt_ready = ready_ff;
      nxt_memEn = memEn_ff;
      nxt_ext_mem_write_n = 1'b1;
      nxt_oe = oe_ff;
      nxt_dOut = dOut_ff;
      nxt_addr = addr_ff;
      nxt_wData = wData_ff;
      nxt_memReg = memReg_ff;
      nxt_rdWr = rdWr_ff;
      nxt_msb = msb_ff;
      nxt_byteHold = byteHold_ff;
      nxt_word = word_ff;
      nxt_req = 1'b0;
      ramWe = 1'b0;
      regWe = 1'b0;
      weData = word_ff;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_cnt = '0;
            if (!bus.strobe_n) begin
               if (late_select_strap) begin
                  nxt_state = ST_SEL;
               end else if (!bus.select_n) begin
                  nxt_state = ST_WAIT;
                  nxt_req = 1'b1;
                  if (dma_transfer_ack_n) begin
                     nxt_state = ST_ACT;
                     nxt_io_enable_n = 1'b0;
                  end
               end
            end
         end
         ST_SEL: begin
            if (bus.strobe_n) begin
               nxt_state = ST_IDLE;
            end else if (bus.select_n) begin
               nxt_state = ST_SKIP;
            end else begin
               nxt_req = 1'b1;
               nxt_state = ST_WAIT;
               if (dma_transfer_ack_n) begin
                  nxt_state = ST_ACT;
                  nxt_io_enable_n = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            nxt_req = 1'b1;
            nxt_cnt = cnt_ff + 1'b1;
            if (bus.strobe_n) begin
               nxt_state = ST_IDLE;
            end else if (grant) begin
               nxt_state = ST_ACT;
               nxt_io_enable_n = 1'b0;
               nxt_cnt = '0;
            end
         end
         ST_ACT: begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CTRL_LATCH_CNT) begin
               nxt_memReg = bus.memReg;
               nxt_rdWr = bus.rdWr;
               nxt_msb = bus.msbLsb;
               nxt_memEn = ~bus.memReg;
               if (!transparent_strap) begin
                  nxt_addr = bus.addr;
                  nxt_wData = bus.data;
               end
            end
            if (cnt_ff == BUS_LATCH_CNT && transparent_strap) begin
               nxt_addr = bus.addr;
               nxt_wData = bus.data;
            end
            if (cnt_ff == ACCESS_CNT) begin
               if (!rdWr_ff) begin
                  if (!wide && !trig) begin
                     nxt_byteHold = wData_ff[7:0];
                  end else begin
                     weData = wide ? wData_ff :
                        (msb_ff ? {wData_ff[7:0], byteHold_ff} : {byteHold_ff, wData_ff[7:0]});
                     ramWe = memReg_ff;
                     regWe = ~memReg_ff;
                     nxt_ext_mem_write_n = ~memReg_ff;
                  end
               end else if (trig) begin
                  nxt_word = memReg_ff ? ram[addr_ff[RAM_AW-1:0]] : regs[addr_ff[REG_AW-1:0]];
               end
            end
            if (cnt_ff == DATA_OUT_CNT && rdWr_ff) begin
               nxt_oe = 1'b1;
               if (wide) begin
                  nxt_dOut = word_ff;
               end else if (trig) begin
                  nxt_dOut = {8'h00, msb_ff ? word_ff[15:8] : word_ff[7:0]};
                  nxt_byteHold = msb_ff ? word_ff[7:0] : word_ff[15:8];
               end else begin
                  nxt_dOut = {8'h00, byteHold_ff};
               end
            end
            if (cnt_ff == READY_CNT) begin
               nxt_ready = 1'b0;
               nxt_state = ST_DONE;
            end
            if (bus.strobe_n) begin
               nxt_state = ST_IDLE;
               nxt_io_enable_n = 1'b1;
               nxt_ready = 1'b1;
               nxt_memEn = 1'b1;
               nxt_oe = 1'b0;
            end
         end
         ST_DONE: begin
            if (bus.strobe_n) begin
               nxt_state = ST_IDLE;
               nxt_io_enable_n = 1'b1;
               nxt_ready = 1'b1;
               nxt_memEn = 1'b1;
               nxt_oe = 1'b0;
            end
         end
         ST_SKIP: begin
            if (bus.strobe_n) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // Registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
         io_enable_n_ff <= 1'b1;
         ready_ff <= 1'b1;
         memEn_ff <= 1'b1;
         ext_mem_write_n_ff <= 1'b1;
         oe_ff <= 1'b0;
         dOut_ff <= '0;
         addr_ff <= '0;
         wData_ff <= '0;
         memReg_ff <= 1'b0;
         rdWr_ff <= 1'b1;
         msb_ff <= 1'b0;
         byteHold_ff <= '0;
         word_ff <= '0;
         req_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         io_enable_n_ff <= nxt_io_enable_n;
         ready_ff <= nxt_ready;
         memEn_ff <= nxt_memEn;
         ext_mem_write_n_ff <= nxt_ext_mem_write_n;
         oe_ff <= nxt_oe;
         dOut_ff <= nxt_dOut;
         addr_ff <= nxt_addr;
         wData_ff <= nxt_wData;
         memReg_ff <= nxt_memReg;
         rdWr_ff <= nxt_rdWr;
         msb_ff <= nxt_msb;
         byteHold_ff <= nxt_byteHold;
         word_ff <= nxt_word;
         req_ff <= nxt_req;
      end
   end

   // ==========================================================
   // Shared RAM and register storage.
   always_ff @(posedge core_clk) begin
      if (ramWe) begin
         ram[addr_ff[RAM_AW-1:0]] <= weData;
      end
      if (regWe) begin
         regs[addr_ff[REG_AW-1:0]] <= weData;
      end
   end

   assign bus.io_enable_n = io_enable_n_ff;
   assign bus.host_ready_n = ready_ff;
   assign bus.ext_mem_enable_n = memEn_ff;
   assign bus.ext_mem_write_n = ext_mem_write_n_ff;
   assign bus.devDataOe = oe_ff;
   assign bus.devData = dOut_ff;
   assign hostAccessReq = req_ff;
endmodule
`default_nettype wire

// File: verilog/host_port_host.sv
// Host end of the host port: runs one strobed cycle per user request.
`timescale 1ns/10ps
`default_nettype none
module host_port_host
   import host_port_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   host_port_if.host bus,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqMem,
   input wire logic reqMsb,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [DATA_W-1:0] reqData,
   output logic reqReady,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData
);
   typedef enum logic [1:0] {H_IDLE, H_ENABLE, H_READY, H_END} hstate_t;

   hstate_t st_ff, nxt_st;
   logic strobe_ff, nxt_strobe;
   logic sel_ff, nxt_sel;
   logic memReg_ff, nxt_memReg;
   logic rdWr_ff, nxt_rdWr;
   logic msb_ff, nxt_msb;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] wd_ff, nxt_wd;
   logic oe_ff, nxt_oe;
   logic rdy_ff, nxt_rdy;
   logic rv_ff, nxt_rv;
   logic [DATA_W-1:0] rd_ff, nxt_rd;

   // ==========================================================
   // Next-state logic.
   always_comb begin
      nxt_st = st_ff;
      nxt_strobe = strobe_ff;
      nxt_sel = sel_ff;
      nxt_memReg = memReg_ff;
      nxt_rdWr = rdWr_ff;
      nxt_msb = msb_ff;
      nxt_addr = addr_ff;
      nxt_wd = wd_ff;
      nxt_oe = oe_ff;
      nxt_rdy = rdy_ff;
      nxt_rv = 1'b0;
      nxt_rd = rd_ff;
      unique case (st_ff)
         H_IDLE: begin
            if (reqValid && rdy_ff) begin
               nxt_strobe = 1'b0;
               nxt_sel = 1'b0;
               nxt_memReg = reqMem;
               nxt_rdWr = ~reqWrite;
               nxt_msb = reqMsb;
               nxt_addr = reqAddr;
               nxt_wd = reqData;
               nxt_oe = reqWrite;
               nxt_rdy = 1'b0;
               nxt_st = H_ENABLE;
            end
         end
         H_ENABLE: begin
            if (!bus.io_enable_n) begin
               nxt_sel = 1'b1;
               nxt_st = H_READY;
            end
         end
         H_READY: begin
            if (!bus.host_ready_n) begin
               nxt_strobe = 1'b1;
               nxt_rd = bus.data;
               nxt_rv = rdWr_ff;
               nxt_st = H_END;
            end
         end
         H_END: begin
            nxt_oe = 1'b0;
            if (bus.host_ready_n) begin
               nxt_rdy = 1'b1;
               nxt_st = H_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // Registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= H_IDLE;
         strobe_ff <= 1'b1;
         sel_ff <= 1'b1;
         memReg_ff <= 1'b0;
         rdWr_ff <= 1'b1;
         msb_ff <= 1'b0;
         addr_ff <= '0;
         wd_ff <= '0;
         oe_ff <= 1'b0;
         rdy_ff <= 1'b1;
         rv_ff <= 1'b0;
         rd_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         strobe_ff <= nxt_strobe;
         sel_ff <= nxt_sel;
         memReg_ff <= nxt_memReg;
         rdWr_ff <= nxt_rdWr;
         msb_ff <= nxt_msb;
         addr_ff <= nxt_addr;
         wd_ff <= nxt_wd;
         oe_ff <= nxt_oe;
         rdy_ff <= nxt_rdy;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
      end
   end

   assign bus.strobe_n = strobe_ff;
   assign bus.select_n = sel_ff;
   assign bus.memReg = memReg_ff;
   assign bus.rdWr = rdWr_ff;
   assign bus.msbLsb = msb_ff;
   assign bus.addr = addr_ff;
   assign bus.hostData = wd_ff;
   assign bus.hostDataOe = oe_ff;
   assign reqReady = rdy_ff;
   assign rspValid = rv_ff;
   assign rspData = rd_ff;
endmodule
`default_nettype wire

// File: verilog/host_port_if.sv
// Pin-level connection between the host processor and the device port.
`timescale 1ns/10ps
`default_nettype none
interface host_port_if;
   import host_port_pkg::*;
   logic strobe_n;
   logic select_n;
   logic memReg;
   logic rdWr;
   logic msbLsb;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] hostData;
   logic hostDataOe;
   logic [DATA_W-1:0] devData;
   logic devDataOe;
   logic [DATA_W-1:0] data;
   logic io_enable_n;
   logic host_ready_n;
   logic ext_mem_enable_n;
   logic ext_mem_write_n;

   // Resolves the shared data bus from the two enables.
   assign data = devDataOe ? devData : (hostDataOe ? hostData : '0);

   modport device (
      input strobe_n, select_n, memReg, rdWr, msbLsb, addr, data,
      output devData, devDataOe, io_enable_n, host_ready_n,
      output ext_mem_enable_n, ext_mem_write_n
   );
   modport host (
      output strobe_n, select_n, memReg, rdWr, msbLsb, addr, hostData, hostDataOe,
      input data, io_enable_n, host_ready_n, ext_mem_enable_n, ext_mem_write_n
   );
endinterface
`default_nettype wire

// File: verilog/host_port_pkg.sv
// Shared constants for the host RAM and register port.
package host_port_pkg;
   // ==========================================================
   // Widths and decode ranges.
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int RAM_AW = 12;
   localparam int REG_AW = 5;
   localparam int CNT_W = 12;
   // ==========================================================
   // Timing figures in their own units and their cycle counts.
   localparam int CLK_MHZ = 250;
   localparam int READY_DELAY_NS = 200;
   localparam int DATA_LEAD_NS = 20;
   localparam int CONTEND_MAX_NS = 2200;
   localparam int READY_CYC = (READY_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int DATA_LEAD_CYC = (DATA_LEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int CONTEND_MAX_CYC = (CONTEND_MAX_NS * CLK_MHZ) / 1000;
   // ==========================================================
   // Points in the cycle, counted in edges after the I/O enable falls; CONTEND_CNT counts edges spent waiting for the grant.
   localparam logic [CNT_W-1:0] CTRL_LATCH_CNT = 12'h000;
   localparam logic [CNT_W-1:0] BUS_LATCH_CNT = 12'h001;
   localparam logic [CNT_W-1:0] ACCESS_CNT = 12'h002;
   localparam logic [CNT_W-1:0] DATA_OUT_CNT = CNT_W'(READY_CYC - 1 - DATA_LEAD_CYC);
   localparam logic [CNT_W-1:0] READY_CNT = CNT_W'(READY_CYC - 1);
   localparam logic [CNT_W-1:0] CONTEND_CNT = CNT_W'(CONTEND_MAX_CYC);
endpackage
